// ===== rtl/port_a_map.vh
// constants for the port a pin function multiplexer
// assumes inclusion by rtl/port_a_pin_function_mux.v only
`ifndef PORT_A_MAP_VH
`define PORT_A_MAP_VH
`define PA_WIDTH        8
`define PA_DIE_RESET    8'hff
`define PA_ZERO         8'h00
`define PA_BIT_IRQ0     0
`define PA_BIT_PWM      3
`define PA_BIT_CMP      4
`define PA_BIT_RESET    5
`define PA_BIT_XOUT     6
`define PA_BIT_XIN      7
`define PA_ANALOG_MASK  8'h19
`define PA_WARM_ZERO    3'h0
`define PA_WARM_SYNCED  1
`define PA_WARM_PRIMED  2
`define EDGE_RISE_BIT   0
`define EDGE_FALL_BIT   1
`define EDGE_RISING     2'b01
`define EDGE_FALLING    2'b10
`define EDGE_BOTH       2'b11
`endif

// ===== rtl/port_a_pin_function_mux.v
// port a pin function multiplexer: gpio, pulls, alternate functions, wake, edge irqs
// assumes control bits come from core logic on clk; pin inputs are asynchronous
//
// Notes on behaviour
// - each pin is digital input or output, pull-high and pull-low chosen independently
// - cleared digital-input-enable bit blocks the input buffer and that pin's wake
// - pin toggle wakes the system from sleep only while its enable bit is set
// - each external irq line requests service on a selectable rising or falling edge
// - bit 4 also carries analog channel 9, comparator plus, minus source 1, irq line 1
// - bit 3 also carries analog channel 8, comparator minus source 0, timer two pwm
// - bit 0 also carries analog channel 10, comparator output, irq line 0
`timescale 1ns/10ps
`include "port_a_map.vh"

module port_a_pin_function_mux (
	input  wire       clk,
	input  wire       rst_b,
	input  wire [7:0] padIn,
	output reg  [7:0] padOut,
	output reg  [7:0] padOe,
	output reg  [7:0] padPullHigh,
	output reg  [7:0] padPullLow,
	output reg  [7:0] padInBufEn,
	input  wire [7:0] portOutData,
	input  wire [7:0] portDirOut,
	input  wire [7:0] pullHighSel,
	input  wire [7:0] pullLowSel,
	input  wire [7:0] digitalInEnable,
	input  wire       sleeping,
	input  wire       crystalUsed,
	input  wire       resetFuncSel,
	input  wire       timerPwmSel,
	input  wire       timer_two_pwm_out,
	input  wire       comparatorOutSel,
	input  wire       comparator_out,
	input  wire [1:0] irqZeroEdge,
	input  wire [1:0] irqOneEdge,
	output reg  [7:0] portInData,
	output reg        wakeRequest,
	output reg        ext_irq_line_zero,
	output reg        ext_irq_line_one,
	output reg        external_reset_low,
	output reg  [7:0] analogSwitch
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: two flops per pin, then a history flop for edge detection

reg  [7:0] padSync1;
reg  [7:0] padSync2;
reg  [7:0] padLast;
reg  [2:0] warm;
wire [7:0] gatedIn;
wire [7:0] gatedLast;
wire [7:0] toggled;
wire       levelValid;
wire       edgesValid;
wire       anyToggle;
wire       irqZeroHit;
wire       irqOneHit;
wire       resetSensed;
wire       pwmOwnsPin;
wire       cmpOwnsPin;
wire       xtalOwnsPins;
wire       resetOwnsPin;

genvar pin;

generate
	for (pin = 0; pin < `PA_WIDTH; pin = pin + 1) begin : g_pinSync
		// only the second stage reads the first, so a metastable level stays contained
		always @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				padSync1[pin] <= 1'b0;
				padSync2[pin] <= 1'b0;
				padLast[pin]  <= 1'b0;
			end else begin
				padSync1[pin] <= padIn[pin];
				padSync2[pin] <= padSync1[pin];
				padLast[pin]  <= padSync2[pin];
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// warm-up: after reset the chain holds zeros, not pin levels, so a pin idling high
// would look like a rising edge; edges and reset sense wait for real samples

// synced after two edges, primed for edge detection after three
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		warm <= `PA_WARM_ZERO;
	end else begin
		warm <= {warm[1:0], 1'b1};
	end
end

assign levelValid = warm[`PA_WARM_SYNCED];
assign edgesValid = warm[`PA_WARM_PRIMED];

////////////////////////////////////////////////////////////////////////////////
// input gating and event detection

function edgeHit;
	input [1:0] sel;
	input       now;
	input       prev;
	begin
		edgeHit = (sel[`EDGE_RISE_BIT] & now & ~prev)
			| (sel[`EDGE_FALL_BIT] & ~now & prev);
	end
endfunction

// a cleared enable bit hides the pin from data, edges and wake alike
assign gatedIn   = padSync2 & digitalInEnable;
assign gatedLast = padLast & digitalInEnable;
assign toggled   = (padSync2 ^ padLast) & digitalInEnable;
assign anyToggle = edgesValid & (|toggled);

// one pulse per qualified edge; select 11 lets both edges through
assign irqZeroHit = edgesValid & edgeHit(irqZeroEdge,
	gatedIn[`PA_BIT_IRQ0], gatedLast[`PA_BIT_IRQ0]);
assign irqOneHit  = edgesValid & edgeHit(irqOneEdge,
	gatedIn[`PA_BIT_CMP], gatedLast[`PA_BIT_CMP]);

// reset sense bypasses the input enable so the pin always works as reset
assign resetSensed = levelValid & resetFuncSel & ~padSync2[`PA_BIT_RESET];

////////////////////////////////////////////////////////////////////////////////
// alternate functions that take a pin away from the port

assign pwmOwnsPin   = timerPwmSel;
assign cmpOwnsPin   = comparatorOutSel;
// crystal pins are never driven digitally; their input buffers rely on software
// clearing the enable bits, else crystal swings on bits 6 and 7 still reach input data and wake
assign xtalOwnsPins = crystalUsed;
assign resetOwnsPin = resetFuncSel;

////////////////////////////////////////////////////////////////////////////////
// output drive and alternate function overrides

reg [7:0] next_out;
reg [7:0] next_oe;
reg [7:0] next_die;
reg [7:0] next_analog;

always @* begin
	next_out    = portOutData;
	next_oe     = portDirOut;
	next_die    = digitalInEnable;
	// analog path of 0, 3 and 4 opens when the digital buffer is off
	next_analog = ~digitalInEnable & `PA_ANALOG_MASK;
	if (pwmOwnsPin) begin
		next_out[`PA_BIT_PWM] = timer_two_pwm_out;
		next_oe[`PA_BIT_PWM]  = 1'b1;
	end
	if (cmpOwnsPin) begin
		next_out[`PA_BIT_IRQ0] = comparator_out;
		next_oe[`PA_BIT_IRQ0]  = 1'b1;
	end
	if (xtalOwnsPins) begin
		next_oe[`PA_BIT_XIN]  = 1'b0;
		next_oe[`PA_BIT_XOUT] = 1'b0;
	end
	if (resetOwnsPin) begin
		next_oe[`PA_BIT_RESET] = 1'b0;
	end
end

// pad drive registers
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		padOut <= `PA_ZERO;
		padOe  <= `PA_ZERO;
	end else begin
		padOut <= next_out;
		padOe  <= next_oe;
	end
end

// buffer, pull and analog switch controls
// both pulls may be on together; the pull-high then wins and the pad reads high
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		padPullHigh  <= `PA_ZERO;
		padPullLow   <= `PA_ZERO;
		padInBufEn   <= `PA_DIE_RESET;
		analogSwitch <= `PA_ZERO;
	end else begin
		padPullHigh  <= pullHighSel;
		padPullLow   <= pullLowSel;
		padInBufEn   <= next_die;
		analogSwitch <= next_analog;
	end
end

////////////////////////////////////////////////////////////////////////////////
// input data, wake, interrupts and reset request

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		portInData         <= `PA_ZERO;
		wakeRequest        <= 1'b0;
		ext_irq_line_zero  <= 1'b0;
		ext_irq_line_one   <= 1'b0;
		external_reset_low <= 1'b1;
	end else begin
		portInData         <= gatedIn;
		// a wake needs the core asleep; awake toggles are ordinary port input
		wakeRequest        <= sleeping & anyToggle;
		ext_irq_line_zero  <= irqZeroHit;
		ext_irq_line_one   <= irqOneHit;
		external_reset_low <= ~resetSensed;
	end
end

endmodule // port_a_pin_function_mux

// ===== verification/port_a_board.sv
// board model: external drivers and pull resistors on port a
// assumes bit n of every vector is pin n
`timescale 1ns/10ps
module port_a_board (
	input  wire [7:0] padOut,
	input  wire [7:0] padOe,
	input  wire [7:0] padPullHigh,
	input  wire [7:0] padPullLow,
	input  wire [7:0] extDrive,
	input  wire [7:0] extEn,
	output wire [7:0] padIn
);
	// a released pin follows its pull; with no pull it reads the inverse of the pad value
	assign padIn = padOe & padOut | ~padOe & (extEn & extDrive
		| ~extEn & (padPullHigh | ~padPullLow & ~padOut));
endmodule // port_a_board

// ===== verification/port_a_pin_function_mux_checker.sv
// assertions on the port a multiplexer, watching its ports only
// assumes bound onto port_a_pin_function_mux, whose port names it shares
`timescale 1ns/10ps
module port_a_mux_checker (
	input wire       clk,
	input wire       rst_b,
	input wire       timerPwmSel,
	input wire       timer_two_pwm_out,
	input wire       comparatorOutSel,
	input wire       comparator_out,
	input wire       sleeping,
	input wire       resetFuncSel,
	input wire       wakeRequest,
	input wire       ext_irq_line_zero,
	input wire       ext_irq_line_one,
	input wire       external_reset_low,
	input wire [7:0] padIn,
	input wire [7:0] padOut,
	input wire [7:0] padOe,
	input wire [7:0] padPullHigh,
	input wire [7:0] padPullLow,
	input wire [7:0] pullHighSel,
	input wire [7:0] pullLowSel,
	input wire [7:0] padInBufEn,
	input wire [7:0] digitalInEnable,
	input wire [7:0] portInData,
	input wire [1:0] irqZeroEdge,
	input wire [1:0] irqOneEdge
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_pull;
		$past(rst_b) |-> {padPullHigh, padPullLow} == $past({pullHighSel, pullLowSel});
	endproperty
	a_pull: assert property (p_pull) else $error("pull");
	property p_buf; $past(rst_b) |-> padInBufEn == $past(digitalInEnable); endproperty
	a_buf: assert property (p_buf) else $error("buffer");
	property p_wake; wakeRequest |-> $past(sleeping); endproperty
	a_wake: assert property (p_wake) else $error("wake");
	// enable held over both samples, so an enable change cannot pose as a pin edge
	property p_irq0;
		$past(rst_b, 4) && $rose(portInData[0]) && $past(digitalInEnable[0])
			&& $past(digitalInEnable[0], 2) && $past(irqZeroEdge[0]) |-> ext_irq_line_zero;
	endproperty
	a_irq0: assert property (p_irq0) else $error("irq0");
	property p_irq1;
		$past(rst_b, 4) && $fell(portInData[4]) && $past(digitalInEnable[4])
			&& $past(digitalInEnable[4], 2) && $past(irqOneEdge[1]) |-> ext_irq_line_one;
	endproperty
	a_irq1: assert property (p_irq1) else $error("irq1");
	property p_rstoe; $past(resetFuncSel) |-> !padOe[5]; endproperty
	a_rstoe: assert property (p_rstoe) else $error("reset pin driven");
	property p_rst; (resetFuncSel && !padIn[5])[*4] |-> !external_reset_low; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_pwm; $past(timerPwmSel) |-> padOut[3] == $past(timer_two_pwm_out); endproperty
	a_pwm: assert property (p_pwm) else $error("pwm");
	property p_cmp; $past(comparatorOutSel) |-> padOut[0] == $past(comparator_out); endproperty
	a_cmp: assert property (p_cmp) else $error("cmp");
endmodule // port_a_mux_checker
bind port_a_pin_function_mux port_a_mux_checker i_chk(.*);

// ===== verification/port_a_pin_function_mux_tb.sv
// self-checking bench for the port a multiplexer
// assumes board model and checker compiled first
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module port_a_pin_function_mux_tb;
	logic clk = 1'h0, rst_b = 1'h0, sleeping = 1'h0, crystalUsed = 1'h0, resetFuncSel = 1'h0;
	logic timerPwmSel = 1'h0, timer_two_pwm_out = 1'h0;
	logic comparatorOutSel = 1'h0, comparator_out = 1'h0;
	logic [7:0] portOutData = 8'h00, portDirOut = 8'h00, pullHighSel = 8'h00, pullLowSel = 8'h00;
	logic [7:0] extDrive = 8'h00, extEn = 8'h00, digitalInEnable = 8'hff;
	logic [1:0] irqZeroEdge = 2'h0, irqOneEdge = 2'h0;
	wire [7:0] padIn, padOut, padOe, padPullHigh, padPullLow, padInBufEn, portInData, analogSwitch;
	wire wakeRequest, ext_irq_line_zero, ext_irq_line_one, external_reset_low;
	int errors = 0, samples_checked = 0;
	// four-state counters, so an unknown pulse cannot pass as zero
	integer wakes = 0, irqs = 0, n = 0;
	port_a_pin_function_mux i_port_a_pin_function_mux(.*);
	port_a_board i_port_a_board(.*);
	always #10 clk = ~clk;
	always @(posedge clk) begin
		wakes <= wakes + wakeRequest;
		irqs <= irqs + ext_irq_line_zero + ext_irq_line_one;
	end
	task automatic step(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic t_pads;
		portDirOut = 8'h06;
		portOutData = 8'h02;
		pullHighSel = 8'h0f;
		pullLowSel = 8'h30;
		extEn = 8'h10;
		extDrive = 8'h10;
		digitalInEnable = 8'hef;
		step(5);
		`CHK("padOut", 2'h1, padOut[2:1])
		`CHK("portInData", 8'hcb, portInData)
		`CHK("analogSwitch", 1'h1, analogSwitch[4])
		`CHK("padOe", 8'h06, padOe)
	endtask
	task automatic t_irq;
		irqZeroEdge = 2'h1;
		irqOneEdge = 2'h2;
		digitalInEnable = 8'hff;
		n = irqs;
		extEn = 8'h11;
		step(6);
		extDrive = 8'h01;
		step(6);
		`CHK("irqs", 2, irqs - n)
	endtask
	task automatic t_wake;
		sleeping = 1'h1;
		n = wakes;
		extEn = 8'h91;
		step(6);
		`CHK("wake", 1, wakes - n)
		crystalUsed = 1'h1;
		digitalInEnable = 8'h3f;
		extDrive = 8'h81;
		step(6);
		`CHK("gated wake", 1, wakes - n)
	endtask
	task automatic t_both;
		irqZeroEdge = 2'h3;
		n = irqs;
		extDrive = 8'h80;
		step(6);
		extDrive = 8'h81;
		step(6);
		`CHK("both edges", 2, irqs - n)
	endtask
	task automatic t_alt;
		{timerPwmSel, timer_two_pwm_out, comparatorOutSel, comparator_out} = 4'hf;
		resetFuncSel = 1'h1;
		portDirOut = 8'he6;
		extEn = 8'hb1;
		step(6);
		`CHK("alt", 3'h6, {padOut[3], padOut[0], external_reset_low})
		`CHK("padOe alt", 8'h0f, padOe)
	endtask
	task automatic end_sim;
		if (errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		step(2);
		rst_b = 1'h1;
		step(1);
		t_pads;
		t_irq;
		t_wake;
		t_both;
		t_alt;
		end_sim;
	end
	initial begin
		#4000;
		errors++;
		end_sim;
	end
endmodule // port_a_pin_function_mux_tb
